/* File: hw/ispr_pin_sync.v */
// Three-stage synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps

module ispr_pin_sync
#(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
)
(
    input wire sys_clk,
    input wire rst,
    input wire [WIDTH-1:0] pinIn,
    output wire [WIDTH-1:0] pinOut
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : gSync
            reg s1;
            reg s2;
            reg s3;
            reg stable;
            // The output moves only once the second and third stages agree.
            always @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                begin
                    s1 <= RESET_VAL[i];
                    s2 <= RESET_VAL[i];
                    s3 <= RESET_VAL[i];
                    stable <= RESET_VAL[i];
                end
                else
                begin
                    s1 <= pinIn[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                        stable <= s3;
                end
            end
            assign pinOut[i] = stable;
        end
    endgenerate

endmodule // ispr_pin_sync

/* File: hw/ispr_port.v */
// Serial in-system-configuration port with reset status logic and APB registers.
// Notes on behaviour
// R1 - Blank part defaults pins to test port.
// R2 - Test pins inputs; data-out drives after enable.
// R3 - Enable command may switch on status lines.
// R4 - Status lines selectable as open-drain.
// R5 - Error line low on failed flash op.
// R6 - Error sticky until clear or disable+reset.
// R7 - Busy high in read mode, low otherwise.
// R8 - Configuration commands only; no boundary scan.
// R9 - Secure part: no reads, chip erase only.
// R10 - Chip erase clears security bit.
// R11 - Erase of protected sector refused.
// R12 - Controller holds reset during programming.
// R13 - Extra ready delay after reset release.
// R14 - Read mode at power-up; lockout blocks writes.
// R15 - Selects low, strobe high at power-on.
// R16 - Resets float pins; clear registers by type.
// R17 - Logic outputs valid through warm reset.
// R18 - Macrocells cleared only by power-on reset.
// R19 - Code-space and peripheral bits cleared on reset.
// R20 - Sample on TCK rise, drive on fall.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "ispr_map.vh"

module ispr_port
(
    input wire sys_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire tckPin,
    input wire tmsPin,
    input wire tdiPin,
    output reg tdoOut,
    output reg tdoOeN,
    output reg iscBusyOut,
    output reg iscBusyOeN,
    output reg iscErrorOut,
    output reg iscErrorOeN,
    input wire chipResetN,
    input wire belowLockout,
    input wire secWriteActive,
    input wire flashDone,
    input wire flashFail,
    input wire [7:0] flashRdData,
    output reg flashStart,
    output reg [1:0] flashOp,
    output reg [2:0] flashSector,
    output reg [7:0] flashAddr,
    output reg [7:0] flashWrData,
    output reg testPortSelected,
    output reg memAccessReady,
    output reg logicOutValid,
    output reg mcuIoOeN,
    output reg addrOutOeN
);

    // ------------
    // Pin synchronisation and TCK edges
    // ------------
    wire [4:0] syncPins;
    ispr_pin_sync #(.WIDTH(5), .RESET_VAL(5'h08)) uSync
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .pinIn({belowLockout, chipResetN, tdiPin, tmsPin, tckPin}),
        .pinOut(syncPins)
    );
    wire tck = syncPins[0];
    wire tms = syncPins[1];
    wire tdi = syncPins[2];
    wire resetPinN = syncPins[3];
    wire lockout = syncPins[4];
    reg tckPrev;
    wire tckRise = tck & ~tckPrev;
    wire tckFall = ~tck & tckPrev;

    // ------------
    // TAP state machine
    // ------------
    localparam [3:0] ST_RESET = 4'd0, ST_IDLE = 4'd1, ST_SEL_DR = 4'd2, ST_CAP_DR = 4'd3,
        ST_SH_DR = 4'd4, ST_EX1_DR = 4'd5, ST_PA_DR = 4'd6, ST_EX2_DR = 4'd7,
        ST_UP_DR = 4'd8, ST_SEL_IR = 4'd9, ST_CAP_IR = 4'd10, ST_SH_IR = 4'd11,
        ST_EX1_IR = 4'd12, ST_PA_IR = 4'd13, ST_EX2_IR = 4'd14, ST_UP_IR = 4'd15;
    reg [3:0] tapState;
    reg [3:0] next_tapState;
    always @*
    begin
        case (tapState)
            ST_RESET: next_tapState = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: next_tapState = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_tapState = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_tapState = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: next_tapState = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_tapState = tms ? ST_UP_DR : ST_PA_DR;
            ST_PA_DR: next_tapState = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: next_tapState = tms ? ST_UP_DR : ST_SH_DR;
            ST_UP_DR: next_tapState = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_tapState = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_tapState = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: next_tapState = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_tapState = tms ? ST_UP_IR : ST_PA_IR;
            ST_PA_IR: next_tapState = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: next_tapState = tms ? ST_UP_IR : ST_SH_IR;
            ST_UP_IR: next_tapState = tms ? ST_SEL_DR : ST_IDLE;
            default: next_tapState = ST_RESET;
        endcase
    end

    // ------------
    // Port state
    // ------------
    reg [3:0] irShift;
    reg [3:0] instr;
    reg [15:0] drShift;
    reg bypassBit;
    reg portEnabled;
    reg [2:0] extCfg;
    reg errorFlag;
    reg disableSeen;
    reg opBusy;
    reg refused;
    reg securityBit;
    reg [7:0] protectBits;
    reg [7:0] powerModeA;
    reg [7:0] powerModeB;
    reg [7:0] memMapCfg;
    reg [15:0] macrocells;
    reg [7:0] readyCount;
    reg resetPinPrev;

    // Anything outside the configuration set falls back to the one-bit bypass path.
    wire isDataInstr = (instr == `ISPR_CMD_ENABLE) || (instr == `ISPR_CMD_PROGRAM) ||
        (instr == `ISPR_CMD_ERASE) || (instr == `ISPR_CMD_CHIP_ERASE) ||
        (instr == `ISPR_CMD_READ) || (instr == `ISPR_CMD_VERIFY); // see R8
    wire atRise = tckRise;
    wire upDr = atRise && (tapState == ST_UP_DR);
    wire upIr = atRise && (tapState == ST_UP_IR);
    wire [3:0] newInstr = irShift;
    wire isFlashCmd = (instr == `ISPR_CMD_PROGRAM) || (instr == `ISPR_CMD_ERASE) ||
        (instr == `ISPR_CMD_CHIP_ERASE);
    wire sectorLocked = protectBits[drShift[2:0]];
    // A start is refused while an operation is busy, while secure (except chip erase), on erase of a protected sector, or in lockout.
    wire startBlocked = lockout || opBusy ||
        (securityBit && (instr != `ISPR_CMD_CHIP_ERASE)) ||
        ((instr == `ISPR_CMD_ERASE) && sectorLocked); // see R9 see R11 see R14
    wire tryStart = upDr && portEnabled && isFlashCmd;
    wire doStart = tryStart && !startBlocked;
    wire isReadCmd = (instr == `ISPR_CMD_READ) || (instr == `ISPR_CMD_VERIFY);
    wire warmRstActive = !resetPinN;
    wire warmRstRise = resetPinN && !resetPinPrev;
    wire errClear = (upIr && portEnabled && (newInstr == `ISPR_CMD_CLEAR)) ||
        (warmRstActive && disableSeen); // see R6
    wire errSet = opBusy && flashDone && flashFail; // see R5

    // ------------
    // Serial shift paths and command execution
    // ------------
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tckPrev <= 1'b0;
            tapState <= ST_RESET;
            irShift <= 4'h0;
            instr <= 4'h0;
            drShift <= 16'h0000;
            bypassBit <= 1'b0;
            portEnabled <= 1'b0;
            extCfg <= 3'h0;
            disableSeen <= 1'b0;
            tdoOut <= 1'b0;
            tdoOeN <= 1'b1;
            flashStart <= 1'b0;
            flashOp <= 2'h0;
            flashSector <= 3'h0;
            flashAddr <= 8'h00;
            flashWrData <= 8'h00;
            opBusy <= 1'b0;
        end
        else
        begin
            tckPrev <= tck;
            flashStart <= doStart;
            if (atRise) // see R20
            begin
                tapState <= next_tapState;
                case (tapState)
                    ST_RESET: instr <= 4'h0;
                    ST_CAP_IR: irShift <= `ISPR_IR_CAPTURE;
                    ST_SH_IR: irShift <= {tdi, irShift[3:1]};
                    ST_UP_IR: instr <= irShift;
                    ST_CAP_DR:
                    begin
                        bypassBit <= 1'b0;
                        // A secured part shifts zeros instead of array contents.
                        if (isReadCmd && !securityBit)
                            drShift <= {flashAddr, flashRdData}; // see R9
                        else
                            drShift <= 16'h0000;
                    end
                    ST_SH_DR:
                    begin
                        bypassBit <= tdi;
                        drShift <= {tdi, drShift[15:1]};
                    end
                    default: instr <= instr;
                endcase
            end
            if (tckFall && ((tapState == ST_SH_DR) || (tapState == ST_SH_IR))) // see R20
            begin
                if (tapState == ST_SH_IR)
                    tdoOut <= irShift[0];
                else if (isDataInstr)
                    tdoOut <= drShift[0];
                else
                    tdoOut <= bypassBit;
            end
            if (upDr && (instr == `ISPR_CMD_ENABLE)) // see R3 see R4
            begin
                portEnabled <= 1'b1;
                extCfg <= drShift[2:0];
            end
            if (upIr && portEnabled && (newInstr == `ISPR_CMD_DISABLE))
            begin
                portEnabled <= 1'b0;
                extCfg <= 3'h0;
                disableSeen <= 1'b1;
            end
            else if (warmRstActive)
                disableSeen <= 1'b0;
            // Data-out stays an input until the enabling command has been taken.
            tdoOeN <= !portEnabled; // see R2
            if (upDr && portEnabled && isReadCmd)
                flashAddr <= drShift[15:8];
            if (doStart)
            begin
                opBusy <= 1'b1;
                flashSector <= drShift[2:0];
                flashAddr <= drShift[15:8];
                flashWrData <= drShift[7:0];
                if (instr == `ISPR_CMD_PROGRAM)
                    flashOp <= `ISPR_OP_PROGRAM;
                else if (instr == `ISPR_CMD_ERASE)
                    flashOp <= `ISPR_OP_ERASE;
                else
                    flashOp <= `ISPR_OP_CHIP;
            end
            else if (opBusy && flashDone)
                opBusy <= 1'b0;
        end
    end

    // ------------
    // Status lines, error flag, reset timing and pin states
    // ------------
    wire busyLevel = !(opBusy || secWriteActive); // see R7 see R14
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            errorFlag <= 1'b0;
            iscBusyOut <= 1'b0;
            iscBusyOeN <= 1'b1;
            iscErrorOut <= 1'b0;
            iscErrorOeN <= 1'b1;
            resetPinPrev <= 1'b1;
            readyCount <= 8'h00;
            memAccessReady <= 1'b0;
            logicOutValid <= 1'b0;
            mcuIoOeN <= 1'b1;
            addrOutOeN <= 1'b1;
            testPortSelected <= 1'b1;
        end
        else
        begin
            // A failure in the same cycle as a clear still leaves the flag set.
            if (errSet)
                errorFlag <= 1'b1; // see R5
            else if (errClear)
                errorFlag <= 1'b0; // see R6
            if (!portEnabled || !extCfg[`ISPR_CFG_BUSY_EN_BIT])
            begin
                iscBusyOut <= 1'b0;
                iscBusyOeN <= 1'b1;
            end
            else if (extCfg[`ISPR_CFG_OD_BIT])
            begin
                iscBusyOut <= 1'b0;
                iscBusyOeN <= busyLevel; // see R4
            end
            else
            begin
                iscBusyOut <= busyLevel; // see R7
                iscBusyOeN <= 1'b0;
            end
            if (!portEnabled || !extCfg[`ISPR_CFG_ERR_EN_BIT])
            begin
                iscErrorOut <= 1'b0;
                iscErrorOeN <= 1'b1;
            end
            else if (extCfg[`ISPR_CFG_OD_BIT])
            begin
                iscErrorOut <= 1'b0;
                iscErrorOeN <= !errorFlag; // see R4
            end
            else
            begin
                iscErrorOut <= !errorFlag; // see R5
                iscErrorOeN <= 1'b0;
            end
            // The test pins are dedicated; nothing in this block reassigns them.
            testPortSelected <= 1'b1; // see R1
            resetPinPrev <= resetPinN;
            if (warmRstActive)
            begin
                readyCount <= 8'h00;
                memAccessReady <= 1'b0;
            end
            else if (readyCount < `ISPR_READY_CYCLES)
                readyCount <= readyCount + 8'h01; // see R13
            else
                memAccessReady <= 1'b1; // see R13
            logicOutValid <= 1'b1; // see R17
            mcuIoOeN <= warmRstActive || !memAccessReady; // see R16
            addrOutOeN <= warmRstActive || !memAccessReady; // see R16
        end
    end

    // ------------
    // APB register file
    // ------------
    wire apbAccess = psel && penable && pready;
    wire apbWrite = apbAccess && pwrite;
    reg [31:0] next_prdata;
    reg next_slverr;
    always @*
    begin
        next_prdata = 32'h00000000;
        next_slverr = 1'b0;
        case (paddr)
            `ISPR_CTRL_OFS: next_prdata = {16'h0000, protectBits, 7'h00, securityBit};
            `ISPR_STAT_OFS: next_prdata = {25'h0000000, refused, memAccessReady, opBusy,
                errorFlag, busyLevel, extCfg[`ISPR_CFG_OD_BIT], portEnabled};
            `ISPR_PMA_OFS: next_prdata = {24'h000000, powerModeA};
            `ISPR_PMB_OFS: next_prdata = {24'h000000, powerModeB};
            `ISPR_MMAP_OFS: next_prdata = {24'h000000, memMapCfg};
            `ISPR_MCELL_OFS: next_prdata = {16'h0000, macrocells};
            default: next_slverr = 1'b1;
        endcase
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            securityBit <= 1'b0;
            protectBits <= 8'h00;
            refused <= 1'b0;
            powerModeA <= 8'h00;
            powerModeB <= 8'h00;
            memMapCfg <= `ISPR_MMAP_INIT;
            macrocells <= 16'h0000;
        end
        else
        begin
            // One wait state gives registered read data and error.
            pready <= psel && penable && !pready;
            if (psel && penable && !pready)
            begin
                prdata <= next_prdata;
                pslverr <= next_slverr;
            end
            if (apbWrite && (paddr == `ISPR_CTRL_OFS))
            begin
                securityBit <= pwdata[`ISPR_CTRL_SEC_BIT];
                protectBits <= pwdata[`ISPR_CTRL_PROT_LSB+7:`ISPR_CTRL_PROT_LSB];
            end
            if (opBusy && flashDone && !flashFail && (flashOp == `ISPR_OP_CHIP))
                securityBit <= 1'b0; // see R10
            if (tryStart && startBlocked)
                refused <= 1'b1; // see R9 see R11
            else if (warmRstActive)
                refused <= 1'b0; // see R16
            else if (apbWrite && (paddr == `ISPR_STAT_OFS) && pwdata[`ISPR_STAT_REFUSED_BIT])
                refused <= 1'b0;
            // Power-mode registers clear only on the power-on reset.
            if (apbWrite && (paddr == `ISPR_PMA_OFS))
                powerModeA <= pwdata[7:0]; // see R16
            if (apbWrite && (paddr == `ISPR_PMB_OFS))
                powerModeB <= pwdata[7:0]; // see R16
            if (warmRstRise)
            begin
                memMapCfg <= `ISPR_MMAP_INIT;
                memMapCfg[`ISPR_MMAP_CODE_BIT] <= 1'b0; // see R19
                memMapCfg[`ISPR_MMAP_PERIPH_BIT] <= 1'b0; // see R19
            end
            else if (apbWrite && (paddr == `ISPR_MMAP_OFS))
                memMapCfg <= pwdata[7:0];
            if (apbWrite && (paddr == `ISPR_MCELL_OFS))
                macrocells <= pwdata[15:0]; // see R18
        end
    end

endmodule // ispr_port

/* File: inc/ispr_map.vh */
// Register offsets, field positions, reset values and timing counts of the programming port.
`ifndef ISPR_MAP_VH
`define ISPR_MAP_VH

// ------------
// Register offsets
// ------------
`define ISPR_CTRL_OFS 8'h00
`define ISPR_STAT_OFS 8'h04
`define ISPR_PMA_OFS 8'h08
`define ISPR_PMB_OFS 8'h0c
`define ISPR_MMAP_OFS 8'h10
`define ISPR_MCELL_OFS 8'h14

// ------------
// Field positions and reset values
// ------------
`define ISPR_CTRL_SEC_BIT 0
`define ISPR_CTRL_PROT_LSB 8
`define ISPR_STAT_REFUSED_BIT 6
`define ISPR_MMAP_CODE_BIT 0
`define ISPR_MMAP_PERIPH_BIT 1
`define ISPR_MMAP_INIT 8'h3c
`define ISPR_CFG_BUSY_EN_BIT 0
`define ISPR_CFG_ERR_EN_BIT 1
`define ISPR_CFG_OD_BIT 2

// ------------
// Serial instruction codes and flash operations
// ------------
`define ISPR_IR_CAPTURE 4'h1
`define ISPR_CMD_ENABLE 4'h2
`define ISPR_CMD_DISABLE 4'h3
`define ISPR_CMD_CLEAR 4'h4
`define ISPR_CMD_PROGRAM 4'h5
`define ISPR_CMD_ERASE 4'h6
`define ISPR_CMD_CHIP_ERASE 4'h7
`define ISPR_CMD_READ 4'h8
`define ISPR_CMD_VERIFY 4'h9
`define ISPR_OP_PROGRAM 2'h0
`define ISPR_OP_ERASE 2'h1
`define ISPR_OP_CHIP 2'h2

// ------------
// Timing
// ------------
`define ISPR_CLK_NS 20
`define ISPR_READY_TIME_NS 1000
`define ISPR_READY_CYCLES ((`ISPR_READY_TIME_NS + `ISPR_CLK_NS - 1) / `ISPR_CLK_NS)

`endif

/* File: tb/ispr_ctl_model.sv */
// Model of the serial programming controller that drives the test-access pins.
`timescale 1ns/1ps

module ispr_ctl_model
(
    input wire sys_clk,
    input wire tdoOut,
    output logic tckPin,
    output logic tmsPin,
    output logic tdiPin
);
    // ------------
    // Bit and scan tasks
    // ------------
    initial
    begin
        tckPin = 1'b0;
        tmsPin = 1'b1;
        tdiPin = 1'b0;
    end
    // TCK rests low between frames, so the block never sees a stray edge.
    task automatic bitx(input logic m, input logic d, output logic q);
    begin
        tmsPin <= m;
        tdiPin <= d;
        repeat (4) @(posedge sys_clk);
        tckPin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        q = tdoOut;
        tckPin <= 1'b0;
    end
    endtask
    task automatic tapReset();
        logic b;
    begin
        repeat (5) bitx(1'b1, 1'b0, b);
        bitx(1'b0, 1'b0, b);
    end
    endtask
    task automatic scan(input logic ir, input int n, input logic [15:0] v,
                        output logic [15:0] q);
        logic b;
    begin
        q = 16'h0000;
        bitx(1'b1, 1'b0, b);
        if (ir)
            bitx(1'b1, 1'b0, b);
        bitx(1'b0, 1'b0, b);
        bitx(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++)
        begin
            bitx(i == n - 1, v[i], b);
            q[i] = b;
        end
        bitx(1'b1, 1'b0, b);
        bitx(1'b0, 1'b0, b);
        repeat (10) @(posedge sys_clk);
    end
    endtask
endmodule // ispr_ctl_model

/* File: tb/ispr_port_sva.sv */
// Checker of the programming port's pin and reset behaviour.
`timescale 1ns/1ps
`include "ispr_map.vh"

module ispr_port_chk
(
    input wire sys_clk,
    input wire rst,
    input wire chipResetN,
    input wire flashStart,
    input wire flashDone,
    input wire flashFail,
    input wire iscBusyOut,
    input wire iscErrorOut,
    input wire testPortSelected,
    input wire memAccessReady,
    input wire logicOutValid,
    input wire mcuIoOeN,
    input wire addrOutOeN
);
    // ------------
    // Properties
    // ------------
    localparam int READY = `ISPR_READY_CYCLES;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [7:0] upCnt;
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst || !chipResetN)
            upCnt <= 8'h00;
        else if (upCnt != 8'hff)
            upCnt <= upCnt + 8'h01;
    end
    sequence s_fail;
        flashDone && flashFail;
    endsequence
    property p_sel; testPortSelected; endproperty
    property p_ready; $rose(memAccessReady) |-> upCnt >= READY; endproperty
    property p_drop; $fell(chipResetN) |-> ##[1:6] !memAccessReady; endproperty
    property p_io; !memAccessReady |-> mcuIoOeN; endproperty
    property p_addr; !memAccessReady |-> addrOutOeN; endproperty
    property p_valid; logicOutValid |=> logicOutValid; endproperty
    property p_err; s_fail |-> ##[1:3] !iscErrorOut; endproperty
    property p_busy; flashStart |-> ##[1:2] !iscBusyOut; endproperty
    a_sel: assert property (p_sel) else $error("test port lost");
    a_ready: assert property (p_ready) else $error("ready too early");
    a_drop: assert property (p_drop) else $error("ready kept in reset");
    a_io: assert property (p_io) else $error("io driven in reset");
    a_addr: assert property (p_addr) else $error("address driven in reset");
    a_valid: assert property (p_valid) else $error("logic output lost");
    a_err: assert property (p_err) else $error("error line not low");
    a_busy: assert property (p_busy) else $error("busy line not low");
endmodule // ispr_port_chk

bind ispr_port ispr_port_chk ispr_port_chk_inst
(
    .sys_clk(sys_clk),
    .rst(rst),
    .chipResetN(chipResetN),
    .flashStart(flashStart),
    .flashDone(flashDone),
    .flashFail(flashFail),
    .iscBusyOut(iscBusyOut),
    .iscErrorOut(iscErrorOut),
    .testPortSelected(testPortSelected),
    .memAccessReady(memAccessReady),
    .logicOutValid(logicOutValid),
    .mcuIoOeN(mcuIoOeN),
    .addrOutOeN(addrOutOeN)
);

/* File: tb/tb.sv */
// Self-checking bench of the programming port.
`timescale 1ns/1ps
`include "ispr_map.vh"
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

module tb;
    // ------------
    // Stimulus, flash side and scenarios
    // ------------
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, chipResetN = 1;
    logic flashDone = 0, flashFail = 0, failNext = 0, rdErr;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdData;
    logic [15:0] q;
    logic [2:0] doneCnt = 0;
    logic [1:0] flashOp, lastOp;
    wire [7:0] flashAddr, flashWrData;
    wire tck, tms, tdi, tdoOut, tdoOeN, iscBusyOut, iscBusyOeN, iscErrorOut, iscErrorOeN;
    wire pready, pslverr, flashStart, memAccessReady, logicOutValid, mcuIoOeN, addrOutOeN;
    int errors = 0, numChecks = 0, cycles = 0, starts = 0, s;
    ispr_port ispr_port_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tckPin(tck),
        .tmsPin(tms), .tdiPin(tdi), .tdoOut(tdoOut), .tdoOeN(tdoOeN),
        .iscBusyOut(iscBusyOut), .iscBusyOeN(iscBusyOeN), .iscErrorOut(iscErrorOut),
        .iscErrorOeN(iscErrorOeN), .chipResetN(chipResetN), .belowLockout(1'b0),
        .secWriteActive(1'b0), .flashDone(flashDone), .flashFail(flashFail),
        .flashRdData(8'h5a), .flashStart(flashStart), .flashOp(flashOp),
        .flashSector(), .flashAddr(flashAddr), .flashWrData(flashWrData), .testPortSelected(),
        .memAccessReady(memAccessReady), .logicOutValid(logicOutValid),
        .mcuIoOeN(mcuIoOeN), .addrOutOeN(addrOutOeN));
    ispr_ctl_model ispr_ctl_model_inst (.sys_clk(sys_clk), .tdoOut(tdoOut),
        .tckPin(tck), .tmsPin(tms), .tdiPin(tdi));
    initial forever #10 sys_clk = ~sys_clk;
    // The flash array answers three cycles after each start.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            summarize();
        end
        flashDone <= 1'b0;
        if (flashStart === 1'b1)
        begin
            starts++;
            lastOp <= flashOp;
            doneCnt <= 3'd3;
        end
        else if (doneCnt != 3'd0)
        begin
            doneCnt <= doneCnt - 3'd1;
            flashDone <= doneCnt == 3'd1;
            flashFail <= failNext;
        end
    end
    task automatic summarize();
    begin
        $display("checks=%0d errors=%0d", numChecks, errors);
        if (errors == 0 && numChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task automatic ir(input logic [3:0] c);
    begin
        ispr_ctl_model_inst.scan(1'b1, 4, {12'h000, c}, q);
    end
    endtask
    task automatic dr(input logic [15:0] v);
    begin
        ispr_ctl_model_inst.scan(1'b0, 16, v, q);
    end
    endtask
    task automatic tReset();
    begin
        `CHK(tdoOeN, 1'b1)
        `CHK(iscBusyOeN, 1'b1)
        apb(1'b0, `ISPR_MMAP_OFS, 0);
        `CHK(rdData, 32'h0000003c)
        apb(1'b0, `ISPR_PMA_OFS, 0);
        `CHK(rdData, 32'h00000000)
        apb(1'b0, 8'h20, 0);
        `CHK(rdErr, 1'b1)
    end
    endtask
    task automatic tEnable();
    begin
        ispr_ctl_model_inst.tapReset();
        ir(`ISPR_CMD_ENABLE);
        dr(16'h0003);
        `CHK(tdoOeN, 1'b0)
        `CHK({iscBusyOeN, iscBusyOut}, 2'b01)
        ir(`ISPR_CMD_ENABLE);
        `CHK(q[3:0], 4'h1)
    end
    endtask
    task automatic prog(input logic f);
    begin
        failNext = f;
        s = starts;
        ir(`ISPR_CMD_PROGRAM);
        dr(16'h1234);
    end
    endtask
    task automatic tFail();
    begin
        prog(1'b1);
        `CHK({flashAddr, flashWrData}, 16'h1234)
        `CHK(starts, s + 1)
        `CHK(lastOp, `ISPR_OP_PROGRAM)
        `CHK({iscErrorOeN, iscErrorOut}, 2'b00)
        ir(`ISPR_CMD_ENABLE);
        dr(16'h0007);
        `CHK({iscErrorOeN, iscErrorOut, iscBusyOeN}, 3'b001)
        ir(`ISPR_CMD_CLEAR);
        `CHK(iscErrorOeN, 1'b1)
    end
    endtask
    task automatic tSecure();
    begin
        apb(1'b1, `ISPR_CTRL_OFS, 1);
        prog(1'b0);
        `CHK(starts, s)
        apb(1'b0, `ISPR_STAT_OFS, 0);
        `CHK(rdData[6], 1'b1)
        ir(`ISPR_CMD_CHIP_ERASE);
        dr(16'h0000);
        `CHK(starts, s + 1)
        `CHK(lastOp, `ISPR_OP_CHIP)
        apb(1'b0, `ISPR_CTRL_OFS, 0);
        `CHK(rdData[0], 1'b0)
    end
    endtask
    task automatic tProtect();
    begin
        apb(1'b1, `ISPR_CTRL_OFS, 32'h00000100);
        apb(1'b1, `ISPR_STAT_OFS, 32'h00000040);
        s = starts;
        ir(`ISPR_CMD_ERASE);
        dr(16'h0000);
        `CHK(starts, s)
        apb(1'b0, `ISPR_STAT_OFS, 0);
        `CHK(rdData[6], 1'b1)
        dr(16'h0001);
        `CHK(starts, s + 1)
        `CHK(lastOp, `ISPR_OP_ERASE)
    end
    endtask
    task automatic tWarm();
    begin
        chipResetN <= 1'b0;
        prog(1'b1);
        `CHK(iscErrorOeN, 1'b0)
        ir(`ISPR_CMD_DISABLE);
        apb(1'b1, `ISPR_PMA_OFS, 32'h000000a5);
        apb(1'b1, `ISPR_MMAP_OFS, 32'h000000ff);
        repeat (10) @(posedge sys_clk);
        `CHK({mcuIoOeN, addrOutOeN, memAccessReady, logicOutValid}, 4'b1101)
        chipResetN <= 1'b1;
        s = 0;
        do begin @(posedge sys_clk); s++; end while (memAccessReady !== 1'b1);
        `CHK(s >= `ISPR_READY_CYCLES, 1'b1)
        apb(1'b0, `ISPR_PMA_OFS, 0);
        `CHK(rdData, 32'h000000a5)
        apb(1'b0, `ISPR_STAT_OFS, 0);
        `CHK(rdData[3], 1'b0)
        apb(1'b0, `ISPR_MMAP_OFS, 0);
        `CHK(rdData, 32'h0000003c)
    end
    endtask
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (80) @(posedge sys_clk);
        tReset();
        tEnable();
        tFail();
        tSecure();
        tProtect();
        tWarm();
        summarize();
    end
endmodule // tb
